// *** rtl/host_mac_pkg.sv ***
// Package: register map, field layout and reset values of the host MAC
// filter and PHY management block.
// Assumes an APB slave with 32-bit data; register byte address = 4 * index.
`default_nettype none
package host_mac_pkg;
  // ==========================================================================
  // Register indices and APB address width
  localparam logic [3:0] IDX_STATION_ADDRESS_LOW = 4'h3;
  localparam logic [3:0] IDX_MULTICAST_HASH_UPPER = 4'h4;
  localparam logic [3:0] IDX_MULTICAST_HASH_LOWER = 4'h5;
  localparam logic [3:0] IDX_PHY_MGMT_ACCESS_CONTROL = 4'h6;
  localparam logic [3:0] IDX_PHY_MGMT_DATA = 4'h7;
  localparam logic [3:0] IDX_HOST_MAC_CONTROL = 4'h8;
  localparam logic [3:0] IDX_STATION_ADDRESS_HIGH = 4'h9;
  localparam int ADDR_W = 8;
  // ==========================================================================
  // Reset values
  localparam logic [31:0] RST_STATION_ADDRESS_LOW = 32'h0FFFFFFF;
  localparam logic [15:0] RST_STATION_ADDRESS_HIGH = 16'hFFFF;
  localparam logic [31:0] RST_HASH = 32'h00000000;
  localparam logic [15:0] RST_PHY_DATA = 16'h0000;
  localparam logic [4:0] RST_PHY_FIELD = 5'h00;
  // ==========================================================================
  // Field positions and the EEPROM address byte count
  localparam int ACC_BUSY_BIT = 0;
  localparam int ACC_DIR_BIT = 1;
  localparam int ACC_INDEX_LSB = 6;
  localparam int ACC_PHY_LSB = 11;
  localparam int CTRL_ACCEPT_ALL_MC_BIT = 0;
  localparam int EE_BYTES = 6;
  // ==========================================================================
  // Management engine states, one-hot
  typedef enum logic [2:0] {
    MG_IDLE = 3'b001,
    MG_REQ  = 3'b010,
    MG_WAIT = 3'b100
  } mgmt_state_t;
endpackage : host_mac_pkg
`default_nettype wire

// *** rtl/eeprom_addr_if.sv ***
// Interface carrying station-address bytes from the EEPROM capture
// module into the register bank.
// Assumes the register bank is the only consumer.
`default_nettype none
interface eeprom_addr_if;
  logic load_valid;
  logic [47:0] address;
  modport src (output load_valid, output address);
  modport dst (input load_valid, input address);
endinterface : eeprom_addr_if
`default_nettype wire

// *** rtl/eeprom_addr_capture.sv ***
// Collects EEPROM bytes 01h..06h into a 48-bit station address.
// Assumes the loader presents one byte per strobe with its EEPROM address.
`default_nettype none
module eeprom_addr_capture
  import host_mac_pkg::*;
(
  input wire logic pclk,            // system clock
  input wire logic presetn,         // async reset, low
  input wire logic ee_byte_valid,   // loader byte strobe
  input wire logic [7:0] ee_byte_addr, // EEPROM byte address
  input wire logic [7:0] ee_byte_data, // EEPROM byte value
  input wire logic ee_load_done,    // loader finished, EEPROM programmed
  eeprom_addr_if.src out            // captured address to register bank
);
  logic [47:0] addr_reg;
  logic done_reg;

  // ==========================================================================
  // Byte lanes: EEPROM byte 01h+k lands in address byte k
  genvar k;
  for (k = 0; k < EE_BYTES; k++) begin : g_lane
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        addr_reg[8*k +: 8] <= 8'h00;
      end else if (ee_byte_valid && ee_byte_addr == 8'(k + 1)) begin
        addr_reg[8*k +: 8] <= ee_byte_data;
      end
    end
  end

  // One-cycle load pulse on loader completion edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= ee_load_done;
    end
  end

  assign out.load_valid = ee_load_done && !done_reg;
  assign out.address = addr_reg;
endmodule : eeprom_addr_capture
`default_nettype wire

// *** rtl/host_mac_filter_and_phy_mgmt.sv ***
// Host MAC station address, multicast hash filter and PHY management access.
// Assumes an APB master, an EEPROM loader byte stream and an internal PHY
// management port with request/done handshake.
// Limitation: one PHY access at a time; access or data
// writes while busy are dropped.
//
// The APB slave port was decided locally.

`default_nettype none
module host_mac_filter_and_phy_mgmt
  import host_mac_pkg::*;
(
  input wire logic pclk,              // system clock, 200 MHz
  input wire logic presetn,           // async reset, low
  // APB slave
  input wire logic psel,              // slave select
  input wire logic penable,           // access phase
  input wire logic pwrite,            // write transfer
  input wire logic [ADDR_W-1:0] paddr, // byte address
  input wire logic [31:0] pwdata,     // write data
  output logic [31:0] prdata,         // read data
  output logic pready,                // transfer done
  output logic pslverr,               // unmapped address
  // EEPROM loader
  input wire logic ee_byte_valid,     // loader byte strobe
  input wire logic [7:0] ee_byte_addr, // EEPROM byte address
  input wire logic [7:0] ee_byte_data, // EEPROM byte value
  input wire logic ee_load_done,      // programmed EEPROM fully read
  // Frame filter
  input wire logic frame_to_host,     // fabric forwards frame to host MAC
  input wire logic frame_multicast,   // frame has group destination
  input wire logic [5:0] frame_hash,  // destination address hash
  output logic frame_accept,          // host MAC accepts frame
  output logic frame_accept_valid,    // decision valid, one cycle
  // PHY management port
  output logic mgmt_req,              // access request, level until done
  output logic mgmt_write,            // 1 write, 0 read
  output logic [4:0] mgmt_phy,        // target PHY
  output logic [4:0] mgmt_reg,        // register within PHY
  output logic [15:0] mgmt_wdata,     // write value
  input wire logic mgmt_done,         // access complete pulse
  input wire logic [15:0] mgmt_rdata, // read value, valid with done
  output logic [47:0] station_address // current station address
);
  eeprom_addr_if ee_if ();

  // Register bank storage
  logic [31:0] station_address_low_reg;
  logic [15:0] station_address_high_reg;
  logic [31:0] multicast_hash_upper_reg;
  logic [31:0] multicast_hash_lower_reg;
  logic accept_all_multicast_reg;
  logic [4:0] target_phy_select_reg;
  logic [4:0] phy_register_index_reg;
  logic access_direction_write_reg;
  logic access_in_progress_reg;
  logic [15:0] phy_mgmt_data_reg;

  // Engine state and APB helpers
  mgmt_state_t state_reg;
  mgmt_state_t state_next;
  logic [31:0] prdata_next;
  logic wr_en;
  logic rd_en;
  logic [3:0] idx;
  logic mapped;
  logic hash_bit;

  // EEPROM byte capture, load pulse on completion
  eeprom_addr_capture u_capture (
    .pclk(pclk),
    .presetn(presetn),
    .ee_byte_valid(ee_byte_valid),
    .ee_byte_addr(ee_byte_addr),
    .ee_byte_data(ee_byte_data),
    .ee_load_done(ee_load_done),
    .out(ee_if.src)
  );

  // ==========================================================================
  // APB decode
  // Misaligned or out-of-range offsets are unmapped
  assign idx = paddr[5:2];
  assign mapped = (paddr[ADDR_W-1:6] == '0)
                  && (paddr[1:0] == 2'b00)
                  && (idx >= IDX_STATION_ADDRESS_LOW)
                  && (idx <= IDX_STATION_ADDRESS_HIGH);
  // Writes land in access phase; reads captured in setup
  assign wr_en = psel && penable && pwrite && mapped;
  assign rd_en = psel && !penable && !pwrite;

  // Zero-wait answer: pready high throughout every access phase
  // so pready and pslverr stand one cycle each; prdata holds until the next read setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
    end
  end

  // Read mux, registered in the setup cycle so prdata comes from a flop
  always_comb begin
    prdata_next = 32'h00000000;
    // Reserved bits read back as zero
    case (idx)
      IDX_STATION_ADDRESS_LOW: prdata_next = station_address_low_reg;
      IDX_MULTICAST_HASH_UPPER: prdata_next = multicast_hash_upper_reg;
      IDX_MULTICAST_HASH_LOWER: prdata_next = multicast_hash_lower_reg;
      IDX_PHY_MGMT_ACCESS_CONTROL: prdata_next = {16'h0000, target_phy_select_reg,
        phy_register_index_reg, 4'h0, access_direction_write_reg, access_in_progress_reg};
      IDX_PHY_MGMT_DATA: prdata_next = {16'h0000, phy_mgmt_data_reg};
      IDX_HOST_MAC_CONTROL: prdata_next = {31'h00000000, accept_all_multicast_reg};
      IDX_STATION_ADDRESS_HIGH: prdata_next = {16'h0000, station_address_high_reg};
      default: prdata_next = 32'h00000000;
    endcase
    // Unmapped offsets always read zero
    if (!mapped) begin
      prdata_next = 32'h00000000;
    end
  end

  // Only read setups refresh prdata
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      prdata <= prdata_next;
    end
  end

  // ==========================================================================
  // Station address: EEPROM load, then software writes win afterwards
  // A write in the load cycle is lost; write after init
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station_address_low_reg <= RST_STATION_ADDRESS_LOW;
      station_address_high_reg <= RST_STATION_ADDRESS_HIGH;
    end else if (ee_if.load_valid) begin
      station_address_low_reg <= ee_if.address[31:0];
      station_address_high_reg <= ee_if.address[47:32];
    end else if (wr_en && idx == IDX_STATION_ADDRESS_LOW) begin
      station_address_low_reg <= pwdata;
    end else if (wr_en && idx == IDX_STATION_ADDRESS_HIGH) begin
      station_address_high_reg <= pwdata[15:0];
    end
  end

  // Mirror for the datapath, one cycle behind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      station_address <= {RST_STATION_ADDRESS_HIGH, RST_STATION_ADDRESS_LOW};
    end else begin
      station_address <= {station_address_high_reg, station_address_low_reg};
    end
  end

  // ==========================================================================
  // Hash table and control
  // Both halves and the accept-all bit reset to zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      multicast_hash_upper_reg <= RST_HASH;
      multicast_hash_lower_reg <= RST_HASH;
      accept_all_multicast_reg <= 1'b0;
    end else if (wr_en) begin
      if (idx == IDX_MULTICAST_HASH_UPPER) begin
        multicast_hash_upper_reg <= pwdata;
      end
      if (idx == IDX_MULTICAST_HASH_LOWER) begin
        multicast_hash_lower_reg <= pwdata;
      end
      if (idx == IDX_HOST_MAC_CONTROL) begin
        accept_all_multicast_reg <= pwdata[CTRL_ACCEPT_ALL_MC_BIT];
      end
    end
  end

  // Top hash bit picks the half, low five bits pick the bit
  // so 000000 is lower bit 0, 111111 is upper bit 31
  assign hash_bit = frame_hash[5] ? multicast_hash_upper_reg[frame_hash[4:0]]
                                  : multicast_hash_lower_reg[frame_hash[4:0]];

  // Decision only for host-bound frames; unicast passes this stage
  // Registered, so the verdict is a clean pulse
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_accept <= 1'b0;
      frame_accept_valid <= 1'b0;
    end else begin
      frame_accept_valid <= frame_to_host;
      frame_accept <= frame_to_host &&
        (!frame_multicast || accept_all_multicast_reg || hash_bit);
    end
  end

  // ==========================================================================
  // Access register fields; frozen while busy so a stray write cannot
  // retarget an access in flight
  // A write with busy clear may only set up fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      target_phy_select_reg <= RST_PHY_FIELD;
      phy_register_index_reg <= RST_PHY_FIELD;
      access_direction_write_reg <= 1'b0;
    end else if (wr_en && idx == IDX_PHY_MGMT_ACCESS_CONTROL && !access_in_progress_reg) begin
      target_phy_select_reg <= pwdata[ACC_PHY_LSB +: 5];
      phy_register_index_reg <= pwdata[ACC_INDEX_LSB +: 5];
      access_direction_write_reg <= pwdata[ACC_DIR_BIT];
    end
  end

  // Busy: set by the write, cleared only by completion
  // Set needs idle, clear needs busy: never together
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      access_in_progress_reg <= 1'b0;
    end else if (wr_en && idx == IDX_PHY_MGMT_ACCESS_CONTROL && !access_in_progress_reg
                 && pwdata[ACC_BUSY_BIT]) begin
      access_in_progress_reg <= 1'b1;
    end else if (state_reg == MG_WAIT && mgmt_done) begin
      access_in_progress_reg <= 1'b0;
    end
  end

  // Data register: software value, or PHY read result at completion
  // Software writes are blocked while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phy_mgmt_data_reg <= RST_PHY_DATA;
    end else if (state_reg == MG_WAIT && mgmt_done && !access_direction_write_reg) begin
      phy_mgmt_data_reg <= mgmt_rdata;
    end else if (wr_en && idx == IDX_PHY_MGMT_DATA && !access_in_progress_reg) begin
      phy_mgmt_data_reg <= pwdata[15:0];
    end
  end

  // ==========================================================================
  // Management engine
  // IDLE waits for busy, REQ launches, WAIT holds to done;
  // a done pulse outside WAIT is ignored
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      MG_IDLE: begin
        if (access_in_progress_reg) begin
          state_next = MG_REQ;
        end
      end
      MG_REQ: begin
        state_next = MG_WAIT;
      end
      MG_WAIT: begin
        if (mgmt_done) begin
          state_next = MG_IDLE;
        end
      end
      default: state_next = MG_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= MG_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Request outputs registered; held steady for the whole access
  // Fields are frozen while busy, so copies cannot move
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mgmt_req <= 1'b0;
      mgmt_write <= 1'b0;
      mgmt_phy <= 5'h00;
      mgmt_reg <= 5'h00;
      mgmt_wdata <= 16'h0000;
    end else begin
      mgmt_req <= (state_next == MG_REQ) || (state_next == MG_WAIT);
      mgmt_write <= access_direction_write_reg;
      mgmt_phy <= target_phy_select_reg;
      mgmt_reg <= phy_register_index_reg;
      mgmt_wdata <= phy_mgmt_data_reg;
    end
  end
endmodule : host_mac_filter_and_phy_mgmt
`default_nettype wire

// *** dv/host_mac_properties.sv ***
// Checker: timing and value properties of the host MAC filter and PHY access.
// Assumes it is bound to the top module and sees only its ports.
`default_nettype none
module host_mac_properties (
  input wire logic pclk, // clock
  input wire logic presetn, // reset low
  input wire logic psel, // select
  input wire logic penable, // access phase
  input wire logic pwrite, // write
  input wire logic [7:0] paddr, // address
  input wire logic [31:0] pwdata, // write data
  input wire logic [31:0] prdata, // read data
  input wire logic pready, // ready
  input wire logic pslverr, // error
  input wire logic ee_byte_valid, // byte strobe
  input wire logic ee_load_done, // load done
  input wire logic [7:0] ee_byte_addr, // byte address
  input wire logic [7:0] ee_byte_data, // byte value
  input wire logic frame_to_host, // frame in
  input wire logic frame_multicast, // group frame
  input wire logic frame_accept, // verdict
  input wire logic frame_accept_valid, // verdict valid
  input wire logic [5:0] frame_hash, // filter hash
  input wire logic mgmt_req, // request
  input wire logic mgmt_write, // write access
  input wire logic mgmt_done, // done pulse
  input wire logic [4:0] mgmt_phy, // target PHY
  input wire logic [4:0] mgmt_reg, // register index
  input wire logic [15:0] mgmt_wdata, // write value
  input wire logic [15:0] mgmt_rdata, // read value
  input wire logic [47:0] station_address // current address
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr_s, rd_s, start, busy_h, all_h, exp_acc, bad_addr;
  logic [15:0] acc_h, data_h;
  logic [63:0] hash_h;
  logic [31:0] exp_rd, exp_q;
  // ==========================================================================
  // Shadow of the management registers
  assign wr_s = psel && penable && pready && pwrite;
  assign rd_s = psel && penable && pready && !pwrite;
  assign start = wr_s && paddr == 8'h18 && pwdata[0] && !busy_h;
  assign bad_addr = paddr < 8'h0C || paddr > 8'h24 || paddr[1:0] != 2'b00;
  // Writes during busy are dropped, so the shadow ignores them too
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_h <= 1'b0;
      acc_h <= 16'h0000;
      data_h <= 16'h0000;
    end else begin
      if (wr_s && paddr == 8'h18 && !busy_h) begin
        acc_h <= pwdata[15:0];
        busy_h <= pwdata[0];
      end else if (mgmt_req && mgmt_done) begin
        busy_h <= 1'b0;
      end
      if (wr_s && paddr == 8'h1C && !busy_h) begin
        data_h <= pwdata[15:0];
      end else if (mgmt_req && mgmt_done && !mgmt_write) begin
        data_h <= mgmt_rdata;
      end
    end
  end
  // Shadow of the filter table and its verdict
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hash_h <= 64'h0;
      all_h <= 1'b0;
      exp_acc <= 1'b0;
    end else begin
      if (wr_s && paddr == 8'h10) hash_h[63:32] <= pwdata;
      if (wr_s && paddr == 8'h14) hash_h[31:0] <= pwdata;
      if (wr_s && paddr == 8'h20) all_h <= pwdata[0];
      exp_acc <= !frame_multicast || all_h || hash_h[frame_hash];
    end
  end
  // Expected read data; station address words are left to the bench
  always_comb begin
    case (paddr)
      8'h10: exp_rd = hash_h[63:32];
      8'h14: exp_rd = hash_h[31:0];
      8'h18: exp_rd = {16'h0000, acc_h[15:6], 4'h0, acc_h[1], busy_h};
      8'h1C: exp_rd = {16'h0000, data_h};
      8'h20: exp_rd = {31'h0, all_h};
      default: exp_rd = 32'h00000000;
    endcase
  end
  // Latched at setup, where the design captures its read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      exp_q <= 32'h00000000;
    end else if (psel && !penable) begin
      exp_q <= exp_rd;
    end
  end
  // ==========================================================================
  // Properties
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence launch_s;
    ##[2:3] mgmt_req;
  endsequence
  req_launch_a: assert property (start |-> launch_s)
    else $error("mgmt request not launched");
  req_hold_a: assert property (mgmt_req && !mgmt_done |=> mgmt_req)
    else $error("mgmt request dropped early");
  req_release_a: assert property (mgmt_req && mgmt_done |=> !mgmt_req)
    else $error("mgmt request held after done");
  idle_no_req_a: assert property (!busy_h |-> !mgmt_req)
    else $error("mgmt request while idle");
  fields_stable_a: assert property (mgmt_req && !mgmt_done |=>
    $stable({mgmt_write, mgmt_phy, mgmt_reg, mgmt_wdata}))
    else $error("mgmt fields moved during access");
  fields_map_a: assert property ($rose(mgmt_req) |->
    mgmt_phy == acc_h[15:11] && mgmt_reg == acc_h[10:6] && mgmt_write == acc_h[1]
    && (!mgmt_write || mgmt_wdata == data_h))
    else $error("mgmt fields differ from registers");
  reg_read_a: assert property (rd_s && paddr != 8'h0C
    && paddr != 8'h24 |-> prdata == exp_q)
    else $error("register read data wrong");
  filter_decision_a: assert property (frame_to_host |=>
    frame_accept_valid && frame_accept == exp_acc)
    else $error("frame verdict wrong");
  filter_idle_a: assert property (!frame_to_host |=> !frame_accept_valid)
    else $error("verdict without frame");
  addr_error_a: assert property (psel && penable && pready |-> pslverr == bad_addr)
    else $error("error response wrong");
endmodule // host_mac_properties
bind host_mac_filter_and_phy_mgmt host_mac_properties chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ee_byte_valid,
  .ee_load_done, .ee_byte_addr, .ee_byte_data, .frame_to_host, .frame_multicast,
  .frame_accept, .frame_accept_valid, .frame_hash, .mgmt_req, .mgmt_write, .mgmt_done,
  .mgmt_phy, .mgmt_reg, .mgmt_wdata, .mgmt_rdata, .station_address);
`default_nettype wire

// *** dv/phy_mgmt_model.sv ***
// Model of the internal PHY management registers behind the access engine.
// Assumes a request level held until done and a one-cycle done pulse.
`default_nettype none
module phy_mgmt_model (
  input wire logic pclk, // clock
  input wire logic presetn, // reset low
  input wire logic mgmt_req, // access request
  input wire logic mgmt_write, // 1 write
  input wire logic [4:0] mgmt_phy, // target PHY
  input wire logic [4:0] mgmt_reg, // register index
  input wire logic [15:0] mgmt_wdata, // write value
  input wire logic [3:0] lat, // answer delay in cycles
  output logic mgmt_done, // done pulse
  output logic [15:0] mgmt_rdata // read value
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:1023];
  logic [3:0] cnt;
  // ==========================================================================
  // Answer lat+1 cycles after the request rises; read data only meaningful with done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 4'h0;
      mgmt_done <= 1'b0;
      mgmt_rdata <= 16'hA5A5;
    end else if (mgmt_req && !mgmt_done) begin
      if (cnt == lat) begin
        cnt <= 4'h0;
        mgmt_done <= 1'b1;
        if (mgmt_write) mem[{mgmt_phy, mgmt_reg}] <= mgmt_wdata;
        else mgmt_rdata <= mem[{mgmt_phy, mgmt_reg}];
      end else begin
        cnt <= cnt + 4'h1;
      end
    end else begin
      mgmt_done <= 1'b0;
      mgmt_rdata <= ~mgmt_rdata; // Stale data never looks valid
    end
  end
endmodule // phy_mgmt_model
`default_nettype wire

// *** dv/host_mac_filter_and_phy_mgmt_bench.sv ***
// Bench: APB master, loader bytes, frames and a PHY model around the block.
// Assumes the checker is bound by its own file.
`default_nettype none
module host_mac_filter_and_phy_mgmt_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, ee_byte_addr = 8'h00, ee_byte_data = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic pready, pslverr, e, frame_accept, frame_accept_valid, mgmt_req, mgmt_write;
  logic ee_byte_valid = 1'b0, ee_load_done = 1'b0, mgmt_done;
  logic frame_to_host = 1'b0, frame_multicast = 1'b0;
  logic [5:0] frame_hash = 6'h00;
  logic [4:0] mgmt_phy, mgmt_reg;
  logic [15:0] mgmt_wdata, mgmt_rdata;
  logic [3:0] lat = 4'h0;
  logic [47:0] station_address;
  int mismatches = 0, n_tests = 0;
  host_mac_filter_and_phy_mgmt dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ee_byte_valid, .ee_byte_addr, .ee_byte_data,
    .ee_load_done, .frame_to_host, .frame_multicast, .frame_hash, .frame_accept,
    .frame_accept_valid, .mgmt_req, .mgmt_write, .mgmt_phy, .mgmt_reg, .mgmt_wdata,
    .mgmt_done, .mgmt_rdata, .station_address);
  phy_mgmt_model model (.pclk, .presetn, .mgmt_req, .mgmt_write, .mgmt_phy, .mgmt_reg,
    .mgmt_wdata, .lat, .mgmt_done, .mgmt_rdata);
  always #2.5 pclk = ~pclk;
  // ==========================================================================
  // Shared tasks
  task automatic end_of_test;
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk(input string n, input logic [47:0] x, input logic [47:0] g);
    n_tests++;
    if (g !== x) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", n, x, g);
    end
  endtask
  // One transfer, held until pready is sampled high, then an idle cycle
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i >= 20) chk("pready wait", 48'h1, 48'h0);
    if (i >= 20) end_of_test;
    @(posedge pclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x, input string n);
    apb(1'b0, a, 32'h0);
    chk(n, 48'(x), 48'(q));
  endtask
  // Busy must clear within a bounded number of polls
  task automatic poll;
    int i;
    i = 0;
    do begin
      apb(1'b0, 8'h18, 32'h0);
      i++;
    end while (q[0] !== 1'b0 && i < 40);
    if (i >= 40) chk("busy poll", 48'h0, 48'h1);
    if (i >= 40) end_of_test;
  endtask
  task automatic frame(input logic mc, input logic [5:0] h, input logic on,
      input logic [63:0] t);
    frame_to_host <= 1'b1;
    frame_multicast <= mc;
    frame_hash <= h;
    @(posedge pclk);
    frame_to_host <= 1'b0;
    @(posedge pclk);
    chk("verdict valid", 48'h1, 48'(frame_accept_valid));
    chk("verdict", 48'(!mc || on || t[h]), 48'(frame_accept));
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_reset;
    chk("station address", 48'hFFFF_0FFF_FFFF, station_address);
    rd(8'h0C, 32'h0FFF_FFFF, "address low");
    rd(8'h10, 32'h0, "hash upper");
    rd(8'h14, 32'h0, "hash lower");
    rd(8'h18, 32'h0, "access");
    rd(8'h1C, 32'h0, "data");
    rd(8'h28, 32'h0, "unmapped data");
    chk("unmapped error", 48'h1, 48'(e));
    $display("test reset done");
  endtask
  task automatic t_eeprom;
    for (int i = 1; i <= 6; i++) begin
      ee_byte_valid <= 1'b1;
      ee_byte_addr <= 8'(i);
      ee_byte_data <= 8'(8'h11 * i);
      @(posedge pclk);
    end
    ee_byte_valid <= 1'b0;
    ee_load_done <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("loaded address", 48'h6655_4433_2211, station_address);
    rd(8'h0C, 32'h4433_2211, "loaded low");
    rd(8'h24, 32'h0000_6655, "loaded high");
    wr(8'h0C, 32'hDEAD_BEEF);
    rd(8'h0C, 32'hDEAD_BEEF, "written low");
    wr(8'h24, 32'h0000_1234);
    rd(8'h24, 32'h0000_1234, "written high");
    $display("test eeprom done");
  endtask
  task automatic t_filter;
    logic [63:0] t;
    logic [5:0] h [8] = '{6'h00, 6'h01, 6'h1F, 6'h20, 6'h21, 6'h3F, 6'h01, 6'h01};
    t = 64'h8000_0001_8000_0001;
    wr(8'h10, t[63:32]);
    wr(8'h14, t[31:0]);
    rd(8'h10, t[63:32], "hash upper");
    for (int i = 0; i < 6; i++) frame(1'b1, h[i], 1'b0, t);
    frame(1'b0, h[6], 1'b0, t);
    wr(8'h20, 32'h1);
    frame(1'b1, h[7], 1'b1, t);
    $display("test filter done");
  endtask
  task automatic t_mgmt;
    lat <= 4'h9;
    wr(8'h1C, 32'hFFFF_BEEF);
    wr(8'h18, 32'hFFFF_1903);
    rd(8'h18, 32'h0000_1903, "busy at once");
    wr(8'h1C, 32'h0000_0000);
    poll;
    rd(8'h1C, 32'h0000_BEEF, "data kept");
    chk("phy written", 48'hBEEF, 48'(model.mem[10'h064]));
    rd(8'h18, 32'h0000_1902, "access fields");
    wr(8'h1C, 32'h0000_0000);
    lat <= 4'h0;
    wr(8'h18, 32'h0000_1901);
    poll;
    rd(8'h1C, 32'h0000_BEEF, "phy read");
    $display("test mgmt done");
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_eeprom;
    t_filter;
    t_mgmt;
    end_of_test;
  end
endmodule // host_mac_filter_and_phy_mgmt_bench
`default_nettype wire
